// *** design/cfg_read_responder.sv ***
// sideband config and error bank read interpreter
// Notes on behaviour
// - bank 2 addr/misc/ctl, bank 4 addr/misc unimplemented
// - uncore banks ignore processor identifier
// - core banks same value for sibling threads
// - disabled core/thread bank: zeros, code 0x90
// - absent link banks: zeros, code 0x40
// - banks 6, 8, 13-16 reserved
// - hung target may never answer
// - external unimplemented: ones pass, or 0x90
// - external address: bus, device, function, register
// - external read: code 0x61, lengths 6/5
// - external read only four-byte reply
// - reply opens with completion code
// - address and data least byte first
// - electrical error bad check, mismatch aborts
// - completion code encodings
// - delivered and answered means pass code
// - local hidden 0x90, absent function zeros
// - local reads ignore locks and enumeration
// - bad local bus: zeros, passing code
// - local read lengths 5 / 2,3,5
// - local read code 0xe1, 1/2/4 bytes
`timescale 1ns/1ps

module cfg_read_responder #(
    parameter logic [7:0]  BANK_CMD      = 8'hA0,
    parameter int          NUM_THREADS   = 16,
    parameter logic [19:0] LINK_BANKS    = 20'h00080,
    parameter int          TIMEOUT_CYC   = cfg_resp_pkg::TGT_TIMEOUT_CYC
) (
    input  wire logic                 core_clk,
    input  wire logic                 resetn,
    input  wire logic                 rx_start,
    input  wire logic [7:0]           rx_wl,
    input  wire logic [7:0]           rx_rl,
    input  wire logic                 rx_valid,
    input  wire logic [7:0]           rx_byte,
    input  wire logic                 rx_end,
    input  wire logic                 rx_elec_err,
    input  wire logic [NUM_THREADS-1:0] thread_off,
    input  wire logic                 link_off,
    output logic                      acc_valid,
    output cfg_resp_pkg::acc_s        acc_req,
    input  wire logic                 tgt_done,
    input  wire logic [7:0]           tgt_cc,
    input  wire logic [63:0]          tgt_data,
    output logic                      tx_valid,
    output logic [7:0]                tx_byte,
    output logic                      tx_last,
    input  wire logic                 tx_ready,
    output logic                      st_valid,
    output cfg_resp_pkg::fcs_e        st_kind,
    output logic                      busy
);

    // ====
    // reset release
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ====
    // helpers
    function automatic logic pair_ok(input logic [7:0] cmd, input logic [7:0] wl,
                                     input logic [7:0] rl, input logic [7:0] got);
        logic ok;
        ok = 1'b0;
        if (cmd == cfg_resp_pkg::CMD_EXT_RD) begin
            ok = (wl == cfg_resp_pkg::WL_EXT) && (rl == cfg_resp_pkg::RL_EXT);
        end else if (cmd == cfg_resp_pkg::CMD_LOC_RD) begin
            ok = (wl == cfg_resp_pkg::WL_LOC) &&
                 ((rl == cfg_resp_pkg::RL_LOC_BYTE) || (rl == cfg_resp_pkg::RL_LOC_WORD) ||
                  (rl == cfg_resp_pkg::RL_LOC_DW));
        end else if (cmd == BANK_CMD) begin
            ok = (wl == cfg_resp_pkg::WL_BANK) && (rl == cfg_resp_pkg::RL_BANK);
        end
        pair_ok = ok && (got == wl);
    endfunction

    function automatic logic [7:0] reply_byte(input logic [7:0] cc, input logic [63:0] d,
                                              input logic [7:0] idx);
        logic [7:0] b;
        b = cc;
        if (idx != 8'h00) begin
            b = d[8*(3'(idx - 8'h01)) +: 8];
        end
        reply_byte = b;
    endfunction

    // ====
    // state
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RECV  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_SEND  = 3'b011,
        ST_DONE  = 3'b100
    } state_e;

    state_e             state_r,    state_nxt;
    logic [7:0]         wl_r,       wl_nxt;
    logic [7:0]         rl_r,       rl_nxt;
    logic [7:0]         pay_r [6],  pay_nxt [6];
    logic [7:0]         cnt_r,      cnt_nxt;
    logic [15:0]        tmo_r,      tmo_nxt;
    logic [7:0]         cc_r,       cc_nxt;
    logic [63:0]        data_r,     data_nxt;
    logic               acc_valid_r, acc_valid_nxt;
    cfg_resp_pkg::acc_s acc_r,      acc_nxt;
    logic               tx_valid_r, tx_valid_nxt;
    logic [7:0]         tx_byte_r,  tx_byte_nxt;
    logic               tx_last_r,  tx_last_nxt;
    logic               st_valid_r, st_valid_nxt;
    cfg_resp_pkg::fcs_e st_kind_r,  st_kind_nxt;

    // decoded request fields
    logic [7:0]  cmd;
    logic [31:0] ext_addr;
    logic [31:0] loc_addr;
    logic [7:0]  proc_id;
    logic [4:0]  bank;
    logic [2:0]  sel;
    logic        core_bank;
    logic        bank_bad;
    logic        thr_off;

    always_comb begin
        cmd      = pay_r[0];
        ext_addr = {pay_r[5], pay_r[4], pay_r[3], pay_r[2]};
        ext_addr[31:cfg_resp_pkg::RSVD_LSB] = 4'h0;
        loc_addr = {8'h00, pay_r[4], pay_r[3], pay_r[2]};
        proc_id  = pay_r[2];
        bank     = pay_r[3][4:0];
        sel      = pay_r[4][2:0];
        core_bank = (bank <= cfg_resp_pkg::BANK_CORE_LAST);
        bank_bad = (pay_r[3] > {3'h0, cfg_resp_pkg::BANK_LAST}) ||
                   cfg_resp_pkg::BANK_RESERVED[bank] ||
                   ((bank == cfg_resp_pkg::BANK_NO_CTL) && (sel == cfg_resp_pkg::SEL_CTL)) ||
                   (((bank == cfg_resp_pkg::BANK_NO_AM_A) || (bank == cfg_resp_pkg::BANK_NO_AM_B))
                    && ((sel == cfg_resp_pkg::SEL_ADDR) || (sel == cfg_resp_pkg::SEL_MISC)));
        thr_off  = (proc_id >= 8'(NUM_THREADS)) ? 1'b1 : thread_off[proc_id[$clog2(NUM_THREADS)-1:0]];
    end

    // ====
    // next state
    always_comb begin
        state_nxt     = state_r;
        wl_nxt        = wl_r;
        rl_nxt        = rl_r;
        pay_nxt       = pay_r;
        cnt_nxt       = cnt_r;
        tmo_nxt       = tmo_r;
        cc_nxt        = cc_r;
        data_nxt      = data_r;
        acc_valid_nxt = acc_valid_r;
        acc_nxt       = acc_r;
        tx_valid_nxt  = tx_valid_r;
        tx_byte_nxt   = tx_byte_r;
        tx_last_nxt   = tx_last_r;
        st_valid_nxt  = 1'b0;
        st_kind_nxt   = st_kind_r;
        case (state_r)
            ST_IDLE: begin
                if (rx_start) begin
                    wl_nxt    = rx_wl;
                    rl_nxt    = rx_rl;
                    cnt_nxt   = 8'h00;
                    state_nxt = ST_RECV;
                end
            end
            ST_RECV: begin
                if (rx_valid && (cnt_r < 8'h06)) begin
                    pay_nxt[cnt_r[2:0]] = rx_byte;
                end
                if (rx_valid) begin
                    cnt_nxt = cnt_r + 8'h01;
                end
                if (rx_end) begin
                    cc_nxt    = cfg_resp_pkg::CC_PASS;
                    data_nxt  = 64'h0;
                    cnt_nxt   = 8'h00;
                    tmo_nxt   = 16'h0;
                    state_nxt = ST_SEND;
                    if (rx_elec_err) begin
                        st_valid_nxt = 1'b1;
                        st_kind_nxt  = cfg_resp_pkg::FCS_BAD;
                        state_nxt    = ST_IDLE;
                    end else if (!pair_ok(cmd, wl_r, rl_r, cnt_r)) begin
                        st_valid_nxt = 1'b1;
                        st_kind_nxt  = cfg_resp_pkg::FCS_ABORT;
                        state_nxt    = ST_IDLE;
                    end else if (cmd == cfg_resp_pkg::CMD_EXT_RD) begin
                        acc_nxt       = '{cfg_resp_pkg::KIND_EXT, ext_addr, 3'h4,
                                          8'h00, 5'h00, 3'h0};
                        acc_valid_nxt = 1'b1;
                        state_nxt     = ST_WAIT;
                    end else if (cmd == cfg_resp_pkg::CMD_LOC_RD) begin
                        if ((loc_addr[cfg_resp_pkg::LBUS_MSB:cfg_resp_pkg::LBUS_LSB] !=
                             cfg_resp_pkg::BUS_IIO) &&
                            (loc_addr[cfg_resp_pkg::LBUS_MSB:cfg_resp_pkg::LBUS_LSB] !=
                             cfg_resp_pkg::BUS_UNCORE)) begin
                            cc_nxt = cfg_resp_pkg::CC_PASS;
                        end else begin
                            // no lock gating
                            acc_nxt       = '{cfg_resp_pkg::KIND_LOC, loc_addr,
                                              3'(rl_r - 8'h01), 8'h00, 5'h00, 3'h0};
                            acc_valid_nxt = 1'b1;
                            state_nxt     = ST_WAIT;
                        end
                    end else begin
                        if (sel >= cfg_resp_pkg::SEL_GLOBAL) begin
                            acc_nxt       = '{cfg_resp_pkg::KIND_BANK, 32'h0, 3'h0,
                                              8'h00, 5'h00, sel};
                            acc_valid_nxt = 1'b1;
                            state_nxt     = ST_WAIT;
                        end else if (bank_bad) begin
                            cc_nxt = cfg_resp_pkg::CC_INVALID;
                        end else if (LINK_BANKS[bank] && link_off) begin
                            cc_nxt = cfg_resp_pkg::CC_PASS;
                        end else if (core_bank && thr_off) begin
                            cc_nxt = cfg_resp_pkg::CC_INVALID;
                        end else begin
                            acc_nxt       = '{cfg_resp_pkg::KIND_BANK, 32'h0, 3'h0,
                                              core_bank ? {proc_id[7:1], 1'b0} : 8'h00,
                                              bank, sel};
                            acc_valid_nxt = 1'b1;
                            state_nxt     = ST_WAIT;
                        end
                    end
                end
            end
            ST_WAIT: begin
                tmo_nxt = tmo_r + 16'h1;
                if (tgt_done) begin
                    cc_nxt        = tgt_cc;
                    data_nxt      = tgt_data;
                    acc_valid_nxt = 1'b0;
                    state_nxt     = ST_SEND;
                end else if (tmo_r >= 16'(TIMEOUT_CYC - 1)) begin
                    cc_nxt        = cfg_resp_pkg::CC_TIMEOUT;
                    data_nxt      = 64'h0;
                    acc_valid_nxt = 1'b0;
                    state_nxt     = ST_SEND;
                end
            end
            ST_SEND: begin
                if (!tx_valid_r) begin
                    tx_valid_nxt = 1'b1;
                    tx_byte_nxt  = reply_byte(cc_r, data_r, 8'h00);
                    tx_last_nxt  = (rl_r == 8'h01);
                    cnt_nxt      = 8'h01;
                end else if (tx_ready) begin
                    if (tx_last_r) begin
                        tx_valid_nxt = 1'b0;
                        tx_last_nxt  = 1'b0;
                        st_valid_nxt = 1'b1;
                        st_kind_nxt  = cfg_resp_pkg::FCS_GOOD;
                        state_nxt    = ST_DONE;
                    end else begin
                        tx_byte_nxt = reply_byte(cc_r, data_r, cnt_r);
                        tx_last_nxt = (cnt_r + 8'h01 == rl_r);
                        cnt_nxt     = cnt_r + 8'h01;
                    end
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ====
    // registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_IDLE;
            wl_r        <= 8'h00;
            rl_r        <= 8'h00;
            pay_r       <= '{default: 8'h00};
            cnt_r       <= 8'h00;
            tmo_r       <= 16'h0000;
            cc_r        <= 8'h00;
            data_r      <= 64'h0;
            acc_valid_r <= 1'b0;
            acc_r       <= '0;
            tx_valid_r  <= 1'b0;
            tx_byte_r   <= 8'h00;
            tx_last_r   <= 1'b0;
            st_valid_r  <= 1'b0;
            st_kind_r   <= cfg_resp_pkg::FCS_GOOD;
        end else begin
            state_r     <= state_nxt;
            wl_r        <= wl_nxt;
            rl_r        <= rl_nxt;
            pay_r       <= pay_nxt;
            cnt_r       <= cnt_nxt;
            tmo_r       <= tmo_nxt;
            cc_r        <= cc_nxt;
            data_r      <= data_nxt;
            acc_valid_r <= acc_valid_nxt;
            acc_r       <= acc_nxt;
            tx_valid_r  <= tx_valid_nxt;
            tx_byte_r   <= tx_byte_nxt;
            tx_last_r   <= tx_last_nxt;
            st_valid_r  <= st_valid_nxt;
            st_kind_r   <= st_kind_nxt;
        end
    end

    // busy: not idle
    logic busy_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt != ST_IDLE);
        end
    end

    assign acc_valid = acc_valid_r;
    assign acc_req   = acc_r;
    assign tx_valid  = tx_valid_r;
    assign tx_byte   = tx_byte_r;
    assign tx_last   = tx_last_r;
    assign st_valid  = st_valid_r;
    assign st_kind   = st_kind_r;
    assign busy      = busy_r;

endmodule

// *** pkg/cfg_resp_pkg.sv ***
// constants and carriers for the sideband configuration read responder
package cfg_resp_pkg;

    // ====
    // command codes and length pairs
    localparam logic [7:0] CMD_EXT_RD  = 8'h61;
    localparam logic [7:0] CMD_LOC_RD  = 8'hE1;
    localparam logic [7:0] WL_EXT      = 8'h06;
    localparam logic [7:0] RL_EXT      = 8'h05;
    localparam logic [7:0] WL_LOC      = 8'h05;
    localparam logic [7:0] RL_LOC_BYTE = 8'h02;
    localparam logic [7:0] RL_LOC_WORD = 8'h03;
    localparam logic [7:0] RL_LOC_DW   = 8'h05;
    localparam logic [7:0] WL_BANK     = 8'h05;
    localparam logic [7:0] RL_BANK     = 8'h09;

    // ====
    // completion codes
    localparam logic [7:0] CC_PASS     = 8'h40;
    localparam logic [7:0] CC_TIMEOUT  = 8'h80;
    localparam logic [7:0] CC_NO_RES   = 8'h81;
    localparam logic [7:0] CC_LOW_PWR  = 8'h82;
    localparam logic [7:0] CC_INVALID  = 8'h90;
    localparam logic [7:0] CC_CTRL_ERR = 8'h91;

    // ====
    // configuration address fields
    localparam int         BUS_MSB     = 27;
    localparam int         BUS_LSB     = 20;
    localparam int         LBUS_MSB    = 23;
    localparam int         LBUS_LSB    = 20;
    localparam int         RSVD_LSB    = 28;
    localparam logic [3:0] BUS_IIO     = 4'h0;
    localparam logic [3:0] BUS_UNCORE  = 4'h1;

    // ====
    // error bank layout
    localparam logic [4:0]  BANK_LAST      = 5'h13;
    localparam logic [4:0]  BANK_CORE_LAST = 5'h03;
    localparam logic [4:0]  BANK_NO_CTL    = 5'h02;
    localparam logic [4:0]  BANK_NO_AM_A   = 5'h02;
    localparam logic [4:0]  BANK_NO_AM_B   = 5'h04;
    localparam logic [19:0] BANK_RESERVED  = 20'h1E140;
    localparam logic [2:0]  SEL_CTL        = 3'h0;
    localparam logic [2:0]  SEL_STATUS     = 3'h1;
    localparam logic [2:0]  SEL_ADDR       = 3'h2;
    localparam logic [2:0]  SEL_MISC       = 3'h3;
    localparam logic [2:0]  SEL_GLOBAL     = 3'h4;

    // ====
    // timing
    localparam int TGT_TIMEOUT_NS  = 10000;
    localparam int CLK_PERIOD_NS   = 8;
    localparam int TGT_TIMEOUT_CYC = TGT_TIMEOUT_NS / CLK_PERIOD_NS;

    // ====
    // types
    typedef enum logic [1:0] {
        KIND_EXT  = 2'b00,
        KIND_LOC  = 2'b01,
        KIND_BANK = 2'b10
    } kind_e;

    typedef enum logic [1:0] {
        FCS_GOOD  = 2'b00,
        FCS_BAD   = 2'b01,
        FCS_ABORT = 2'b10
    } fcs_e;

    typedef struct packed {
        kind_e       kind;
        logic [31:0] addr;
        logic [2:0]  nbytes;
        logic [7:0]  proc_id;
        logic [4:0]  bank;
        logic [2:0]  sel;
    } acc_s;

endpackage

// *** verification/cfg_resp_properties.sv ***
// port assertions for the read responder
`timescale 1ns/1ps

module cfg_resp_properties #(
    parameter int TIMEOUT_CYC = 16
) (
    input wire logic          core_clk,
    input wire logic          resetn,
    input wire logic          acc_valid,
    input cfg_resp_pkg::acc_s acc_req,
    input wire logic          tgt_done,
    input wire logic [7:0]    tgt_cc,
    input wire logic          tx_valid,
    input wire logic [7:0]    tx_byte,
    input wire logic          tx_last,
    input wire logic          tx_ready,
    input wire logic          st_valid,
    input cfg_resp_pkg::fcs_e st_kind,
    input wire logic          busy
);
    // ====
    // helper state
    int         wait_cnt;
    logic [7:0] cc_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wait_cnt <= 0;
            cc_r     <= 8'h00;
        end else begin
            wait_cnt <= acc_valid ? wait_cnt + 1 : 0;
            if (acc_valid && tgt_done) begin
                cc_r <= tgt_cc;
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // ====
    // assertions
    chk_done_drops_acc: assert property (acc_valid && tgt_done |=> !acc_valid)
        else $error("access held after answer");
    chk_req_held: assert property (acc_valid && $past(acc_valid) |-> $stable(acc_req))
        else $error("request moved while pending");
    chk_wait_bound: assert property (wait_cnt <= TIMEOUT_CYC + 2)
        else $error("access past timeout");
    chk_ext_rsvd_zero: assert property (acc_valid && acc_req.kind == cfg_resp_pkg::KIND_EXT
        |-> acc_req.addr[31:28] == 4'h0)
        else $error("reserved bits passed");
    chk_ext_four: assert property (acc_valid && acc_req.kind == cfg_resp_pkg::KIND_EXT
        |-> acc_req.nbytes == 3'h4)
        else $error("ext size not four");
    chk_loc_bus_ok: assert property (acc_valid && acc_req.kind == cfg_resp_pkg::KIND_LOC
        |-> acc_req.addr[23:20] <= 4'h1)
        else $error("bad bus forwarded");
    chk_cc_first: assert property (acc_valid && tgt_done
        |-> ##[1:3] (tx_valid && tx_byte == cc_r))
        else $error("reply lacks code first");
    chk_tx_hold: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_byte) && $stable(tx_last))
        else $error("byte moved before taken");
    chk_st_pulse: assert property (st_valid |=> !st_valid)
        else $error("status too long");
    chk_fail_quiet: assert property (st_valid && st_kind != cfg_resp_pkg::FCS_GOOD
        |-> !tx_valid && !acc_valid)
        else $error("failed frame active");
    chk_busy_cover: assert property (tx_valid || acc_valid |-> busy)
        else $error("activity while not busy");
endmodule

bind cfg_read_responder cfg_resp_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
    .core_clk(core_clk), .resetn(resetn), .acc_valid(acc_valid), .acc_req(acc_req),
    .tgt_done(tgt_done), .tgt_cc(tgt_cc), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_last(tx_last), .tx_ready(tx_ready), .st_valid(st_valid), .st_kind(st_kind),
    .busy(busy));

// *** verification/cfg_target_model.sv ***
// model of the internal access target
`timescale 1ns/1ps

module cfg_target_model (
    input wire logic          core_clk,
    input wire logic          resetn,
    input wire logic          acc_valid,
    input cfg_resp_pkg::acc_s acc_req,
    input wire logic [3:0]    delay,
    input wire logic          mute,
    input wire logic [7:0]    cc,
    output logic              tgt_done,
    output logic [7:0]        tgt_cc,
    output logic [63:0]       tgt_data
);
    logic [3:0]  cnt;
    logic [63:0] resp;

    // bank data echoes proc id, else the address
    always_comb begin
        if (acc_req.kind == cfg_resp_pkg::KIND_BANK) begin
            resp = {32'hFEDCBA98, 8'h00, acc_req.proc_id, 3'h0, acc_req.bank, 5'h00, acc_req.sel};
        end else begin
            resp = {32'h2468ACE0, acc_req.addr};
        end
    end

    // mute models a hung target
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt      <= 4'h0;
            tgt_done <= 1'h0;
            tgt_cc   <= 8'h00;
            tgt_data <= 64'h0;
        end else if (tgt_done) begin
            tgt_done <= 1'h0;
            tgt_cc   <= ~tgt_cc;
            tgt_data <= ~tgt_data;
            cnt      <= 4'h0;
        end else if (acc_valid && !mute && cnt >= delay) begin
            tgt_done <= 1'h1;
            tgt_cc   <= cc;
            tgt_data <= resp;
        end else begin
            cnt      <= acc_valid ? cnt + 4'h1 : 4'h0;
            tgt_data <= ~tgt_data;
        end
    end
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the read responder
`timescale 1ns/1ps

module tb_top;
    typedef logic [7:0] bq_t[$];

    logic               core_clk, resetn, rx_start, rx_valid, rx_end, rx_elec_err;
    logic [7:0]         rx_wl, rx_rl, rx_byte, tgt_cc, tx_byte, mdl_cc;
    logic [15:0]        thread_off;
    logic               link_off, acc_valid, tgt_done, tx_valid, tx_last, tx_ready;
    logic               st_valid, busy, mdl_mute;
    logic [63:0]        tgt_data;
    logic [3:0]         mdl_delay;
    cfg_resp_pkg::acc_s acc_req, last_req;
    cfg_resp_pkg::fcs_e st_kind;
    int                 errors, checks, accs;

    cfg_read_responder #(.TIMEOUT_CYC(16)) u_cfg_read_responder (
        .core_clk(core_clk), .resetn(resetn), .rx_start(rx_start), .rx_wl(rx_wl),
        .rx_rl(rx_rl), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
        .rx_elec_err(rx_elec_err), .thread_off(thread_off), .link_off(link_off),
        .acc_valid(acc_valid), .acc_req(acc_req), .tgt_done(tgt_done), .tgt_cc(tgt_cc),
        .tgt_data(tgt_data), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
        .tx_ready(tx_ready), .st_valid(st_valid), .st_kind(st_kind), .busy(busy));

    cfg_target_model u_cfg_target_model (
        .core_clk(core_clk), .resetn(resetn), .acc_valid(acc_valid), .acc_req(acc_req),
        .delay(mdl_delay), .mute(mdl_mute), .cc(mdl_cc), .tgt_done(tgt_done),
        .tgt_cc(tgt_cc), .tgt_data(tgt_data));

    always @(posedge acc_valid) begin
        #1;
        last_req = acc_req;
        accs++;
    end

    // ====
    // shared tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic bq_t le(input logic [7:0] cc, input logic [63:0] v, input int n);
        bq_t q;
        q = '{cc};
        for (int i = 0; i < n; i++) begin
            q.push_back(v[8*i +: 8]);
        end
        return q;
    endfunction

    task automatic send(input bq_t b, input logic [7:0] wl, rl, input logic ee);
        @(posedge core_clk);
        rx_start <= 1'h1;
        rx_wl    <= wl;
        rx_rl    <= rl;
        foreach (b[i]) begin
            @(posedge core_clk);
            rx_start <= 1'h0;
            rx_valid <= 1'h1;
            rx_byte  <= b[i];
        end
        @(posedge core_clk);
        rx_valid    <= 1'h0;
        rx_end      <= 1'h1;
        rx_elec_err <= ee;
        @(posedge core_clk);
        rx_end      <= 1'h0;
        rx_elec_err <= 1'h0;
    endtask

    task automatic wait_st(input cfg_resp_pkg::fcs_e kind);
        for (int k = 0; k < 40; k++) begin
            @(negedge core_clk);
            if (st_valid === 1'h1) break;
        end
        chk(st_valid, 1'h1);
        chk(st_kind, kind);
    endtask

    task automatic idle();
        for (int k = 0; k < 60 && busy !== 1'h0; k++) @(negedge core_clk);
        chk(busy, 1'h0);
    endtask

    // stall every third cycle
    task automatic reply(input bq_t exp);
        int n;
        n = 0;
        for (int k = 0; k < 300 && n < exp.size(); k++) begin
            @(negedge core_clk);
            if (tx_valid === 1'h1 && tx_ready === 1'h1) begin
                chk(tx_byte, exp[n]);
                chk(tx_last, n == exp.size() - 1);
                n++;
            end
            @(posedge core_clk);
            tx_ready <= (k % 3) != 1;
        end
        chk(n, exp.size());
        wait_st(cfg_resp_pkg::FCS_GOOD);
        idle();
    endtask

    task automatic refuse(input bq_t b, input logic [7:0] wl, rl);
        send(b, wl, rl, 1'h0);
        wait_st(cfg_resp_pkg::FCS_ABORT);
        idle();
    endtask

    task automatic bank_one(input logic [7:0] pid, bk, sel, input logic lo,
                            input logic [7:0] cc, epid);
        int a;
        a = accs;
        link_off <= lo;
        send('{8'hA0, 8'h00, pid, bk, sel}, 8'h05, 8'h09, 1'h0);
        if (epid === 8'hFF) reply(le(cc, 64'h0, 8));
        else reply(le(cc, {32'hFEDCBA98, 8'h00, epid, bk, sel}, 8));
        chk(accs - a, epid !== 8'hFF);
        if (epid !== 8'hFF) chk(last_req.proc_id, epid);
    endtask

    // ====
    // scenarios
    task automatic t_ext();
        send('{8'h61, 8'h00, 8'h67, 8'h45, 8'h23, 8'hF1}, 8'h06, 8'h05, 1'h0);
        reply(le(8'h40, 64'h0123_4567, 4));
        chk(last_req.kind, cfg_resp_pkg::KIND_EXT);
        chk(last_req.addr, 32'h0123_4567);
        chk(last_req.nbytes, 3'h4);
        mdl_cc    <= 8'h90;
        mdl_delay <= 4'h9;
        send('{8'h61, 8'h00, 8'hFF, 8'hFF, 8'h0F, 8'h00}, 8'h06, 8'h05, 1'h0);
        reply(le(8'h90, 64'h000F_FFFF, 4));
        mdl_cc   <= 8'h40;
        mdl_mute <= 1'h1;
        send('{8'h61, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00}, 8'h06, 8'h05, 1'h0);
        reply(le(8'h80, 64'h0, 4));
        mdl_mute <= 1'h0;
    endtask

    task automatic t_fault();
        int a;
        a = accs;
        send('{8'h61, 8'h00, 8'h67, 8'h45, 8'h23, 8'h01}, 8'h06, 8'h05, 1'h1);
        wait_st(cfg_resp_pkg::FCS_BAD);
        idle();
        refuse('{8'h61, 8'h00, 8'h67, 8'h45, 8'h23, 8'h01}, 8'h06, 8'h03);
        refuse('{8'h61, 8'h00, 8'h67, 8'h45, 8'h23}, 8'h05, 8'h05);
        refuse('{8'hE1, 8'h00, 8'h34, 8'h12, 8'h08}, 8'h05, 8'h04);
        refuse('{8'hE1, 8'h00, 8'h34, 8'h12}, 8'h05, 8'h05);
        chk(accs, a);
    endtask

    task automatic t_loc();
        logic [7:0] rl;
        logic [3:0] bus;
        int         a;
        for (int s = 0; s < 6; s++) begin
            rl  = (s % 3 == 0) ? 8'h02 : (s % 3 == 1) ? 8'h03 : 8'h05;
            bus = (s < 3) ? 4'h0 : 4'h1;
            mdl_delay <= 4'(s);
            send('{8'hE1, 8'h00, 8'h34, 8'h12, {bus, 4'h8}}, 8'h05, rl, 1'h0);
            reply(le(8'h40, {32'h2468ACE0, 8'h00, bus, 20'h81234}, rl - 1));
            chk(last_req.nbytes, rl - 1);
            chk(last_req.addr[23:0], {bus, 20'h81234});
        end
        a = accs;
        send('{8'hE1, 8'h00, 8'h34, 8'h12, 8'h28}, 8'h05, 8'h05, 1'h0);
        reply(le(8'h40, 64'h0, 4));
        chk(accs, a);
    endtask

    task automatic t_bank();
        bank_one(8'h03, 8'h01, 8'h01, 1'h0, 8'h40, 8'h02);
        bank_one(8'h05, 8'h05, 8'h01, 1'h0, 8'h40, 8'h00);
        bank_one(8'h08, 8'h00, 8'h04, 1'h0, 8'h40, 8'h00);
        bank_one(8'h08, 8'h00, 8'h01, 1'h0, 8'h90, 8'hFF);
        bank_one(8'h00, 8'h07, 8'h01, 1'h1, 8'h40, 8'hFF);
        bank_one(8'h00, 8'h06, 8'h01, 1'h0, 8'h90, 8'hFF);
        bank_one(8'h00, 8'h0D, 8'h01, 1'h0, 8'h90, 8'hFF);
        bank_one(8'h00, 8'h02, 8'h02, 1'h0, 8'h90, 8'hFF);
        bank_one(8'h00, 8'h04, 8'h03, 1'h0, 8'h90, 8'hFF);
        bank_one(8'h00, 8'h02, 8'h00, 1'h0, 8'h90, 8'hFF);
    endtask

    // ====
    // run control
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        #200000;
        errors++;
        print_verdict();
    end

    initial begin
        {resetn, rx_start, rx_valid, rx_end, rx_elec_err, link_off, mdl_mute} = '0;
        {rx_wl, rx_rl, rx_byte, mdl_delay} = '0;
        thread_off = 16'h0100;
        tx_ready   = 1'h1;
        mdl_cc     = 8'h40;
        repeat (2) @(posedge core_clk);
        resetn <= 1'h1;
        repeat (3) @(posedge core_clk);
        t_ext();
        t_fault();
        t_loc();
        t_bank();
        print_verdict();
    end
endmodule
